// file: hdl/tpd_triac_timer.v
/*
  Triac phase delay timer channel with an Avalon-MM register slave.
  Assumes one 25 MHz clock, sync pins from a zero-crossing detector
  and a gate pin driving an external triac.
*/
// How it works
// - Sync edge selectable rising, falling or both; falling when none chosen.
// - Multiplexed channel picks sync from four pins; dedicated channel uses first.
// - New delay or control takes effect only at next active sync edge.
// - Active sync edge restarts timer; gate asserts after programmed delay.
// - Cycle repeats every active edge with same value until rewritten.
// - Stretched gate asserts after delay, releases at terminal count or edge.
// - Stretched gate idles high, active low; invert bit flips polarity.
// - Stretched control value is eight bits, 0-193 at 50 Hz, 0-160 at 60 Hz.
// - Zero gives widest pulse; top value gives narrowest, just before crossing.
// - Control value counts timer ticks, half-cycle count follows line frequency.
// - Frequency accepts 40 to 70 Hz and sets half-cycle terminal count.
// - Software may rewrite terminal count while the timer runs.
// - Delay or control write stalls bus up to 10 ms awaiting an edge.
// - Fixed gate pulse is 25 us wide, normally low, clock independent.
// - Fixed pulse gated by 25.6 us slow clock, one period jitter.
// - Sync edge and gate polarity configured independently.
// - Fixed pulse delay 65535 suppresses the gate entirely.
// - Both-edge sensing only in fixed pulse configuration.
`timescale 1ns/1ps
`include "tpd_triac_map.vh"
module tpd_triac_timer #(
  parameter DEDICATED = 0,
  parameter TMO_CYC = `TPD_TMO_CYC
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Sync pins, fifth to eighth general inputs
  input wire [3:0] sync_pin,
  // Triac gate
  output reg gate_out
);
  // Integer macros, cut to the counter widths on purpose
  localparam [31:0] STR_TICK32 = `TPD_STR_TICK_CYC;
  localparam [31:0] FIX_TICK32 = `TPD_FIX_TICK_CYC;
  localparam [31:0] GATE_CYC32 = `TPD_GATE_CYC;
  localparam [10:0] STR_TICK = STR_TICK32[10:0];
  localparam [10:0] FIX_TICK = FIX_TICK32[10:0];
  localparam [9:0] GATE_CYC = GATE_CYC32[9:0];
  localparam [31:0] HALF_NUM = `TPD_HALF_NUM;
  localparam [31:0] TERM_RST32 = `TPD_HALF_NUM / `TPD_FREQ_RST;
  localparam [15:0] TERM_RST = TERM_RST32[15:0];
  localparam [31:0] TMO_LAST = TMO_CYC - 1;

  reg [7:0] act_ctrl_reg;
  reg [15:0] act_delay_reg;
  reg [7:0] pend_ctrl_reg;
  reg [15:0] pend_delay_reg;
  reg pend_flag_reg;
  reg [7:0] freq_reg;
  reg [15:0] term_reg;
  reg done_reg;
  reg [31:0] wait_reg;
  reg [10:0] div_reg;
  reg [15:0] cnt_reg;
  reg run_reg;
  reg [9:0] pw_reg;
  reg lvl_reg;
  reg [31:0] rdata_next;
  reg [7:0] fclamp;
  reg [1:0] sel_d_reg;

  wire sel_ctrl = avs_address[4:2] == `TPD_OFF_CTRL >> 2;
  wire sel_delay = avs_address[4:2] == `TPD_OFF_DELAY >> 2;
  wire sel_freq = avs_address[4:2] == `TPD_OFF_FREQ >> 2;
  wire sel_term = avs_address[4:2] == `TPD_OFF_TERM >> 2;
  wire sel_stat = avs_address[4:2] == `TPD_OFF_STATUS >> 2;
  wire stall_wr = avs_write & (sel_ctrl | sel_delay);
  wire stall_wait = stall_wr & ~done_reg;

  wire en = act_ctrl_reg[`TPD_CTRL_EN];
  wire fixed = act_ctrl_reg[`TPD_CTRL_FIXED];
  wire inv = act_ctrl_reg[`TPD_CTRL_INV];
  wire pulse_cfg = act_ctrl_reg[`TPD_CTRL_PULSE];
  wire [1:0] edge_cfg = act_ctrl_reg[`TPD_CTRL_EDGE_HI:`TPD_CTRL_EDGE_LO];
  wire [1:0] sel_cfg = act_ctrl_reg[`TPD_CTRL_SEL_HI:`TPD_CTRL_SEL_LO];

  // Both edges fall back to falling outside fixed pulse use
  wire both_ok = fixed & pulse_cfg;
  wire rise_en = (edge_cfg == `TPD_EDGE_RISE) |
                 ((edge_cfg == `TPD_EDGE_BOTH) & both_ok);
  wire fall_en = ~rise_en | (edge_cfg == `TPD_EDGE_BOTH);
  wire [1:0] pin_sel = (DEDICATED != 0) ? 2'h0 : sel_cfg;

  wire sync_level;
  wire act_edge_raw;

  tpd_sync_edge #(
    .PINS(4)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .sync_pin(sync_pin),
    .sel(pin_sel),
    .rise_en(rise_en),
    .fall_en(fall_en),
    .sync_level(sync_level),
    .active_edge(act_edge_raw)
  );

  // Pin switch compares new pin with old history: mask that one cycle,
  // else a level difference between the pins would look like an edge
  wire act_edge = act_edge_raw & (pin_sel == sel_d_reg);

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sel_d_reg <= 2'h0;
    else
      sel_d_reg <= pin_sel;
  end

  // Values to apply at the next edge, including a write stalled right now
  wire [7:0] new_ctrl = (stall_wait & sel_ctrl) ? avs_writedata[7:0] : pend_ctrl_reg;
  wire [15:0] new_delay = (stall_wait & sel_delay) ? avs_writedata[15:0] : pend_delay_reg;
  wire timeout = stall_wait & (wait_reg >= TMO_LAST);
  wire stall_go = stall_wait & (act_edge | timeout);

  assign avs_waitrequest = (avs_read | avs_write) & ~done_reg;

  // Bus handshake: one wait cycle, or up to the timeout for stalled writes
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      done_reg <= 1'b0;
      wait_reg <= 32'h0000_0000;
    end
    else
    begin
      if (done_reg)
        done_reg <= 1'b0;
      else if (avs_read | (avs_write & ~stall_wr) | stall_go)
        done_reg <= 1'b1;
      if (stall_wait & ~stall_go)
        wait_reg <= wait_reg + 32'h0000_0001;
      else
        wait_reg <= 32'h0000_0000;
    end
  end

  // Pending and active configuration
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      act_ctrl_reg <= `TPD_CTRL_RST;
      act_delay_reg <= `TPD_DELAY_RST;
      pend_ctrl_reg <= `TPD_CTRL_RST;
      pend_delay_reg <= `TPD_DELAY_RST;
      pend_flag_reg <= 1'b0;
    end
    else
    begin
      if (stall_go)
      begin
        pend_ctrl_reg <= new_ctrl;
        pend_delay_reg <= new_delay;
      end
      if (act_edge)
      begin
        act_ctrl_reg <= new_ctrl;
        act_delay_reg <= new_delay;
        pend_flag_reg <= 1'b0;
      end
      else if (stall_go)
        pend_flag_reg <= 1'b1;
    end
  end

  // Line frequency and terminal count
  always @*
  begin
    fclamp = avs_writedata[7:0];
    if (avs_writedata[31:0] < {24'h000000, `TPD_FREQ_MIN})
      fclamp = `TPD_FREQ_MIN;
    else if (avs_writedata[31:0] > {24'h000000, `TPD_FREQ_MAX})
      fclamp = `TPD_FREQ_MAX;
  end

  wire [31:0] term_quot = HALF_NUM / {24'h000000, fclamp};
  // Plain writes land at the edge that sees waitrequest low
  wire wr_now = avs_write & ~stall_wr & done_reg;

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      freq_reg <= `TPD_FREQ_RST;
      term_reg <= TERM_RST;
    end
    else if (wr_now & sel_freq)
    begin
      freq_reg <= fclamp;
      term_reg <= term_quot[15:0];
    end
    else if (wr_now & sel_term)
      term_reg <= avs_writedata[15:0];
  end

  // Tick divider; restarted by the edge in stretched mode to keep jitter low,
  // free running in fixed mode so the slow gating clock shows its jitter
  wire [10:0] tick_len = fixed ? FIX_TICK : STR_TICK;
  wire tick = div_reg >= tick_len - 11'h001;

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      div_reg <= 11'h000;
    else if ((act_edge & ~fixed) | tick)
      div_reg <= 11'h000;
    else
      div_reg <= div_reg + 11'h001;
  end

  // Phase counter restarted on every active edge
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
    end
    else if (act_edge)
    begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b1;
    end
    else if (tick & (cnt_reg != 16'hFFFF))
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // Fixed mode: fire at the slow tick where the count meets the delay
  wire fire = en & fixed & run_reg & tick & (cnt_reg == act_delay_reg) &
              (act_delay_reg != `TPD_DELAY_OFF);

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pw_reg <= 10'h000;
      lvl_reg <= 1'b0;
    end
    else
    begin
      if (fire & pulse_cfg)
        pw_reg <= GATE_CYC;
      else if (pw_reg != 10'h000)
        pw_reg <= pw_reg - 10'h001;
      if (act_edge | ~fixed)
        lvl_reg <= 1'b0;
      else if (fire & ~pulse_cfg)
        lvl_reg <= 1'b1;
    end
  end

  // Stretched mode: on from delay point to terminal count
  wire str_on = run_reg & (cnt_reg >= {8'h00, act_delay_reg[7:0]}) &
                (cnt_reg < term_reg);
  wire gate_act = en & (fixed ? (pulse_cfg ? (pw_reg != 10'h000) : lvl_reg) : str_on);

  // Stretched idles high, fixed idles low; invert flips either
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      gate_out <= 1'b1;
    else if (fixed)
      gate_out <= gate_act ^ inv;
    else
      gate_out <= ~(gate_act ^ inv);
  end

  // Read data
  always @*
  begin
    rdata_next = 32'h0000_0000;
    if (sel_ctrl)
      rdata_next = {24'h000000, pend_ctrl_reg};
    else if (sel_delay)
      rdata_next = {16'h0000, pend_delay_reg};
    else if (sel_freq)
      rdata_next = {24'h000000, freq_reg};
    else if (sel_term)
      rdata_next = {16'h0000, term_reg};
    else if (sel_stat)
      rdata_next = {cnt_reg, 12'h000, run_reg, sync_level, pend_flag_reg, gate_act};
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~done_reg)
      avs_readdata <= rdata_next;
  end
endmodule

// file: hdl/tpd_triac_map.vh
/*
  Register offsets, field positions, reset values and timing counts
  for the triac phase delay timer. Assumes a 25 MHz system clock.
*/
`ifndef TPD_TRIAC_MAP_VH
`define TPD_TRIAC_MAP_VH

// Clock
`define TPD_CLK_MHZ 25

// Register byte offsets
`define TPD_OFF_CTRL 5'h00
`define TPD_OFF_DELAY 5'h04
`define TPD_OFF_FREQ 5'h08
`define TPD_OFF_TERM 5'h0C
`define TPD_OFF_STATUS 5'h10

// Control fields
`define TPD_CTRL_EN 0
`define TPD_CTRL_FIXED 1
`define TPD_CTRL_INV 2
`define TPD_CTRL_EDGE_LO 3
`define TPD_CTRL_EDGE_HI 4
`define TPD_CTRL_PULSE 5
`define TPD_CTRL_SEL_LO 6
`define TPD_CTRL_SEL_HI 7
`define TPD_CTRL_RST 8'h00

// Edge selection codes
`define TPD_EDGE_DEF 2'h0
`define TPD_EDGE_RISE 2'h1
`define TPD_EDGE_FALL 2'h2
`define TPD_EDGE_BOTH 2'h3

// Delay and line frequency
`define TPD_DELAY_RST 16'h0000
`define TPD_DELAY_OFF 16'hFFFF
`define TPD_FREQ_MIN 8'h28
`define TPD_FREQ_MAX 8'h46
`define TPD_FREQ_RST 8'h32

// Stretched mode timer tick and half-cycle scale
`define TPD_STR_TICK_NS 51800
`define TPD_STR_TICK_CYC ((`TPD_STR_TICK_NS * `TPD_CLK_MHZ) / 1000)
`define TPD_HALF_NUM (500000000 / `TPD_STR_TICK_NS)

// Fixed mode slow gating clock and gate width
`define TPD_FIX_TICK_NS 25600
`define TPD_FIX_TICK_CYC ((`TPD_FIX_TICK_NS * `TPD_CLK_MHZ) / 1000)
`define TPD_GATE_NS 25000
`define TPD_GATE_CYC ((`TPD_GATE_NS * `TPD_CLK_MHZ + 999) / 1000)

// Longest stall of a delay or control write
`define TPD_TMO_MS 10
`define TPD_TMO_CYC (`TPD_TMO_MS * `TPD_CLK_MHZ * 1000)

`endif

// file: hdl/tpd_sync_edge.v
/*
  Sync pin synchroniser, pin select and edge detector.
  Assumes the sync pins are asynchronous to clock.
*/
`timescale 1ns/1ps
module tpd_sync_edge #(
  parameter PINS = 4
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Pins and selection
  input wire [PINS-1:0] sync_pin,
  input wire [1:0] sel,
  input wire rise_en,
  input wire fall_en,
  // Results
  output wire sync_level,
  output wire active_edge
);
  reg [PINS-1:0] meta_reg;
  reg [PINS-1:0] sync_reg;
  reg prev_reg;
  genvar i;

  // Two flops per pin before the mux reads anything
  generate
    for (i = 0; i < PINS; i = i + 1)
    begin : g_sync
      always @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_reg[i] <= 1'b1;
          sync_reg[i] <= 1'b1;
        end
        else
        begin
          meta_reg[i] <= sync_pin[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_level = sync_reg[sel];

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prev_reg <= 1'b1;
    else
      prev_reg <= sync_level;
  end

  assign active_edge = (rise_en & sync_level & ~prev_reg) |
                       (fall_en & ~sync_level & prev_reg);
endmodule

// file: tb/tpd_zc_model.sv
/* Zero-crossing source for the triac timer bench.
   Assumes the bench selects the carrying pin and stops it with run. */
`timescale 1ns/1ps
module tpd_zc_model #(
  parameter HALF_NS = 160013
) (
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Sync pins
  output wire logic [3:0] sync_pin
);
  reg zc = 1'h1;
  reg noise = 1'h0;
  // Scaled half cycle, off the clock grid so edges stay asynchronous
  always #(HALF_NS) if (run) zc = ~zc;
  // Unselected pins toggle, so a wrong pin choice shows up
  always #131 if (run) noise = ~noise;
  assign sync_pin = ({4{noise}} & ~(4'h1 << sel)) | ({3'h0, zc} << sel);
endmodule

// file: tb/tpd_triac_timer_chk.sv
/* Port checker for the triac phase delay timer.
   Assumes a bind into tpd_triac_timer that passes its TMO_CYC. */
`timescale 1ns/1ps
module tpd_triac_timer_chk #(
  parameter int TMO_CYC = 200
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Pins
  input wire logic [3:0] sync_pin,
  input wire logic gate_out
);
  localparam int TMO_LIM = TMO_CYC + 2;
  localparam int TMO_SAFE = TMO_CYC - 4;
  reg [19:0] wait_cnt, hi_cnt, chg_cnt;
  reg [3:0] pin_d;
  reg [7:0] ctrl_w;
  wire ctl_wr = avs_write && avs_address[4:3] == 2'h0;
  wire fixp = ctrl_w[1] && ctrl_w[5];
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Coarse cause counter: any pin change clears it, noise included
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      wait_cnt <= 20'h0;
      hi_cnt <= 20'h0;
      chg_cnt <= 20'h0;
      pin_d <= 4'h0;
      ctrl_w <= 8'h0;
    end
    else
    begin
      wait_cnt <= (avs_write && avs_waitrequest) ? wait_cnt + 20'h1 : 20'h0;
      hi_cnt <= gate_out ? hi_cnt + 20'h1 : 20'h0;
      pin_d <= sync_pin;
      chg_cnt <= (pin_d != sync_pin) ? 20'h0 : chg_cnt + 20'h1;
      if (ctl_wr && !avs_waitrequest && !avs_address[2])
        ctrl_w <= avs_writedata[7:0];
    end
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest while idle");
  property p_rd;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_wr_bound;
    avs_write && avs_waitrequest |-> wait_cnt < TMO_LIM;
  endproperty
  a_wr_bound: assert property (p_wr_bound) else $error("write stall too long");
  property p_wr_first;
    $rose(avs_write) && ctl_wr |-> avs_waitrequest;
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("write not held");
  property p_wr_cause;
    ctl_wr && !avs_waitrequest && wait_cnt < TMO_SAFE |-> chg_cnt <= 20'h8;
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write ended w/o edge");
  property p_rst_gate;
    $rose(nrst) |-> gate_out [*2];
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("gate active at reset");
  property p_en_off;
    ctl_wr && !avs_waitrequest && !avs_address[2] && avs_writedata[1:0] == 2'h0
      && wait_cnt < TMO_SAFE |-> ##2 gate_out == !$past(avs_writedata[2], 2);
  endproperty
  a_en_off: assert property (p_en_off) else $error("disabled gate level");
  property p_fix_width;
    $fell(gate_out) && fixp && hi_cnt < 20'd1000 |-> hi_cnt >= 20'd625 && hi_cnt <= 20'd627;
  endproperty
  a_fix_width: assert property (p_fix_width) else $error("fixed pulse width");
  c_fix: cover property ($fell(gate_out) && fixp);
  c_tmo: cover property (ctl_wr && !avs_waitrequest && wait_cnt >= TMO_SAFE);
  c_stall: cover property ($rose(avs_write) && ctl_wr);
endmodule
bind tpd_triac_timer tpd_triac_timer_chk #(.TMO_CYC(TMO_CYC)) chk_u (.clock(clock),
  .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .sync_pin(sync_pin),
  .gate_out(gate_out));

// file: tb/tpd_triac_timer_bench.sv
/* Self-checking bench for the triac phase delay timer.
   Assumes the zero-crossing model and the bound checker. */
`timescale 1ns/1ps
`include "tpd_triac_map.vh"
module tpd_triac_timer_bench;
  reg clock = 1'h0, nrst = 1'h0, run = 1'h1, rd = 1'h0, wr = 1'h0, lvl;
  reg [4:0] adr = 5'h0;
  reg [31:0] wd = 32'h0, seed = 32'h9C74, got;
  reg [1:0] psel = 2'h0;
  reg [7:0] f;
  integer n_mismatch = 0, n_compared = 0, cyc = 0, i, t;
  wire [31:0] rdata;
  wire wreq, gate;
  wire [3:0] pins;
  always #20 clock = ~clock;
  tpd_triac_timer #(.TMO_CYC(8100)) dut_u (.clock(clock), .nrst(nrst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .sync_pin(pins), .gate_out(gate));
  tpd_zc_model zc_u (.run(run), .sel(psel), .sync_pin(pins));
  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic [31:0] term_of(input [7:0] q);
    return 9652 / (q < `TPD_FREQ_MIN ? `TPD_FREQ_MIN : q > `TPD_FREQ_MAX ? `TPD_FREQ_MAX : q);
  endfunction
  task results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  task span(input integer lo, input integer hi);
    chk(t >= lo && t <= hi, 1);
  endtask
  task bus(input w, input [4:0] a, input [31:0] d);
    @(posedge clock);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clock);
    while (wreq !== 1'h0)
      @(posedge clock);
    got = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  // Gate is registered behind the new state: let it settle first
  task wctl(input [31:0] d);
    bus(1, `TPD_OFF_CTRL, d);
    lvl = pins[d[7:6]];
    repeat (3) @(posedge clock);
  endtask
  task gwait(input v);
    t = 0;
    while (gate !== v && t < 8600)
    begin
      @(posedge clock);
      t++;
    end
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      n_mismatch++;
      results;
    end
  end
  initial
  begin
    repeat (6) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    chk(gate, 1);
    bus(0, `TPD_OFF_FREQ, 0);
    chk(got, `TPD_FREQ_RST);
    bus(0, 5'h14, 0);
    chk(got, 32'h0);
    wctl(4);
    chk(gate, 0);
    for (i = 0; i < 7; i++)
    begin
      seed = xs(seed);
      f = i == 0 ? 8'h10 : i == 1 ? 8'h50 : i == 2 ? 8'h3C : 8'h28 + seed % 31;
      bus(1, `TPD_OFF_FREQ, f);
      bus(0, `TPD_OFF_TERM, 0);
      chk(got, term_of(f));
    end
    bus(1, `TPD_OFF_FREQ, `TPD_FREQ_RST);
    bus(1, `TPD_OFF_DELAY, 2);
    wctl(1);
    chk(lvl, 0);
    gwait(0);
    span(2575, 2600);
    gwait(1);
    span(5400, 5420);
    gwait(0);
    span(2575, 2600);
    bus(1, `TPD_OFF_TERM, 4);
    gwait(1);
    gwait(0);
    gwait(1);
    span(2575, 2600);
    wctl(13);
    chk(lvl, 0);
    wctl(13);
    chk(lvl, 1);
    gwait(1);
    span(2575, 2600);
    psel <= 2'h2;
    wctl(8'h81);
    wctl(8'h81);
    chk(lvl, 0);
    bus(1, `TPD_OFF_DELAY, 3);
    wctl(8'hBB);
    gwait(1);
    gwait(0);
    span(624, 627);
    bus(1, `TPD_OFF_DELAY, `TPD_DELAY_OFF);
    repeat (3) @(posedge clock);
    gwait(1);
    chk(gate, 0);
    run <= 1'h0;
    repeat (10) @(posedge clock);
    bus(1, `TPD_OFF_DELAY, 5);
    bus(0, `TPD_OFF_STATUS, 0);
    chk(got[1], 1);
    results;
  end
endmodule
